// [apmc_pkg.sv]
// Function
// - supply-up starts in standby until commanded
// - measure bit D3 at 0x2d starts sampling
// - clearing measure bit returns to standby
// - registers stay accessible during standby
// - host configures first, then sets measure
// - sensing off in standby, on in measurement
// - rate code doubles rate per step
// - low-power bit lowers internal sampling rate
// - low power only with codes 0111..1100
// - host writes thresholds, then autosleep plus pairing
// - autosleep samples below 8 Hz
// - standby keeps buffered samples readable
// - first data after period plus 1.1 ms
package apmc_pkg;
   localparam int          DATA_W            = 8;
   localparam int          ADDR_W            = 8;
   // device register map
   localparam logic [7:0]  ADDR_INACT_THRESH = 8'h25;
   localparam logic [7:0]  ADDR_INACT_TIME   = 8'h26;
   localparam logic [7:0]  ADDR_RATE_CTRL    = 8'h2c;
   localparam logic [7:0]  ADDR_POWER_CTRL   = 8'h2d;
   localparam logic [7:0]  ADDR_SAMPLE_DATA  = 8'h32;
   localparam logic [7:0]  ADDR_BUF_LEVEL    = 8'h39;
   // field positions
   localparam int          RATE_LOW_POWER    = 4;
   localparam int          PWR_MEASURE       = 3;
   localparam int          PWR_AUTO_SLEEP    = 4;
   localparam int          PWR_PAIR          = 5;
   // reset values
   localparam logic [7:0]  RST_INACT_THRESH  = 8'h00;
   localparam logic [7:0]  RST_INACT_TIME    = 8'h00;
   localparam logic [7:0]  RST_RATE_CTRL     = 8'h0a;
   localparam logic [7:0]  RST_POWER_CTRL    = 8'h00;
   // rate codes
   localparam logic [3:0]  RATE_CODE_MAX     = 4'hf;
   localparam logic [3:0]  RATE_LP_LO        = 4'h7;
   localparam logic [3:0]  RATE_LP_HI        = 4'hc;
   localparam logic [3:0]  SLEEP_RATE_CODE   = 4'h6;
   // sample buffer
   localparam int          BUF_DEPTH         = 32;
   localparam int          BUF_AW            = 5;
   // timing
   localparam int          CLK_MHZ           = 40;
   localparam int          TOP_RATE_HZ       = 3200;
   localparam int          TURNON_US         = 1100;
   localparam logic [31:0] BASE_PERIOD_CYC   = 32'(CLK_MHZ * 1000000 / TOP_RATE_HZ);
   localparam logic [31:0] TURNON_CYC        = 32'(TURNON_US * CLK_MHZ);
   // host software map
   localparam logic [3:0]  HOFS_RATE         = 4'h0;
   localparam logic [3:0]  HOFS_THRESH       = 4'h1;
   localparam logic [3:0]  HOFS_TIME         = 4'h2;
   localparam logic [3:0]  HOFS_POWER        = 4'h3;
   localparam logic [3:0]  HOFS_CTRL         = 4'h4;
   localparam logic [3:0]  HOFS_STATUS       = 4'h5;
   localparam logic [3:0]  HOFS_RAW_ADDR     = 4'h6;
   localparam logic [3:0]  HOFS_RAW_DATA     = 4'h7;
   localparam int          CTRL_START        = 0;
   localparam int          CTRL_RAW_RD       = 1;
   localparam int          CTRL_RAW_WR       = 2;
endpackage

// [apmc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface apmc_if;
   logic                        wr_stb;
   logic                        rd_stb;
   logic [apmc_pkg::ADDR_W-1:0] addr;
   logic [apmc_pkg::DATA_W-1:0] wdata;
   logic [apmc_pkg::DATA_W-1:0] rdata;

   modport device (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
   modport host   (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

// [apmc_device.sv]
`timescale 1ns/1ps
`default_nettype none
module apmc_device #(
   parameter logic [31:0] BASE_PERIOD_CYC = apmc_pkg::BASE_PERIOD_CYC,
   parameter logic [31:0] TURNON_CYC      = apmc_pkg::TURNON_CYC
) (
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_n_i,
   apmc_if.device                           link,
   input  wire logic [apmc_pkg::DATA_W-1:0] accel_i,
   output logic                             measuring_o,
   output logic                             asleep_o,
   output logic                             sense_on_o,
   output logic                             conv_stb_o,
   output logic                             sample_rdy_o,
   output logic [apmc_pkg::DATA_W-1:0]      sample_o
);
   import apmc_pkg::*;

   typedef enum logic [3:0] {
      ST_STBY  = 4'b0001,
      ST_WAKE  = 4'b0010,
      ST_RUN   = 4'b0100,
      ST_SLEEP = 4'b1000
   } apmc_dev_state_t;

   apmc_dev_state_t     state_reg;
   logic [7:0]          thresh_reg;
   logic [7:0]          time_reg;
   logic [7:0]          rate_reg;
   logic [7:0]          power_reg;
   logic [31:0]         timer_reg;
   logic [7:0]          idle_cnt_reg;
   logic [7:0]          buf_mem [BUF_DEPTH];
   logic [BUF_AW-1:0]   wr_ptr_reg;
   logic [BUF_AW-1:0]   rd_ptr_reg;
   logic [BUF_AW:0]     level_reg;

   logic                measure;
   logic                auto_en;
   logic                inactive;
   logic                idle_hit;
   logic                active;
   logic                sample_tick;
   logic                push;
   logic                pop;
   logic [7:0]          accel_mag;
   logic [31:0]         run_period;

   // output period in clock cycles, halving per code step up
   function automatic logic [31:0] period_cyc(input logic [3:0] code);
      period_cyc = BASE_PERIOD_CYC << (RATE_CODE_MAX - code);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   assign measure     = power_reg[PWR_MEASURE];
   assign auto_en     = power_reg[PWR_AUTO_SLEEP] & power_reg[PWR_PAIR] & measure;
   assign accel_mag   = accel_i[7] ? 8'(-accel_i) : accel_i;
   assign inactive    = accel_mag < thresh_reg;
   assign idle_hit    = inactive && (time_reg != 8'h00) && ((idle_cnt_reg + 8'h01) >= time_reg);
   assign active      = (state_reg != ST_STBY) && measure;
   assign sample_tick = active && (timer_reg <= 32'h1);
   assign run_period  = period_cyc(rate_reg[3:0]);
   assign push        = sample_tick && (level_reg != (BUF_AW+1)'(BUF_DEPTH));
   assign pop         = link.rd_stb && (link.addr == ADDR_SAMPLE_DATA) && (level_reg != '0);

   ////////////////////////////////////////////////////////////////////////////////
   // register writes are taken in every mode
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thresh_reg <= RST_INACT_THRESH;
         time_reg   <= RST_INACT_TIME;
         rate_reg   <= RST_RATE_CTRL;
         power_reg  <= RST_POWER_CTRL;
      end else if (link.wr_stb) begin
         unique case (link.addr)
            ADDR_INACT_THRESH: thresh_reg <= link.wdata;
            ADDR_INACT_TIME:   time_reg   <= link.wdata;
            ADDR_RATE_CTRL:    rate_reg   <= link.wdata;
            ADDR_POWER_CTRL:   power_reg  <= link.wdata;
            default: ;
         endcase
      end
   end

   // read data stand in the cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link.rdata <= '0;
      end else if (link.rd_stb) begin
         unique case (link.addr)
            ADDR_INACT_THRESH: link.rdata <= thresh_reg;
            ADDR_INACT_TIME:   link.rdata <= time_reg;
            ADDR_RATE_CTRL:    link.rdata <= rate_reg;
            ADDR_POWER_CTRL:   link.rdata <= power_reg;
            ADDR_SAMPLE_DATA:  link.rdata <= (level_reg != '0) ? buf_mem[rd_ptr_reg] : 8'h00;
            ADDR_BUF_LEVEL:    link.rdata <= 8'(level_reg);
            default:           link.rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_STBY;
         timer_reg <= '0;
      end else if (!measure) begin
         state_reg <= ST_STBY;
         timer_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_STBY: begin
               state_reg <= ST_WAKE;
               timer_reg <= run_period + TURNON_CYC;
            end
            ST_WAKE: begin
               if (timer_reg <= 32'h1) begin
                  state_reg <= ST_RUN;
                  timer_reg <= run_period;
               end else begin
                  timer_reg <= timer_reg - 32'h1;
               end
            end
            ST_RUN: begin
               if (timer_reg <= 32'h1) begin
                  if (auto_en && idle_hit) begin
                     state_reg <= ST_SLEEP;
                     timer_reg <= period_cyc(SLEEP_RATE_CODE);
                  end else begin
                     timer_reg <= run_period;
                  end
               end else begin
                  timer_reg <= timer_reg - 32'h1;
               end
            end
            ST_SLEEP: begin
               // motion or loss of the autosleep or pairing bit ends sleep through a fresh turn-on
               if (!auto_en || ((timer_reg <= 32'h1) && !inactive)) begin
                  state_reg <= ST_WAKE;
                  timer_reg <= run_period + TURNON_CYC;
               end else if (timer_reg <= 32'h1) begin
                  timer_reg <= period_cyc(SLEEP_RATE_CODE);
               end else begin
                  timer_reg <= timer_reg - 32'h1;
               end
            end
         endcase
      end
   end

   // consecutive quiet samples, counted only while running
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_cnt_reg <= '0;
      end else if (state_reg != ST_RUN) begin
         idle_cnt_reg <= '0;
      end else if (sample_tick) begin
         if (!inactive) begin
            idle_cnt_reg <= '0;
         end else if (idle_cnt_reg != 8'hff) begin
            idle_cnt_reg <= idle_cnt_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // full-power running converts twice per output period; low power, wake and sleep once
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_stb_o   <= 1'b0;
         sense_on_o   <= 1'b0;
         measuring_o  <= 1'b0;
         asleep_o     <= 1'b0;
         sample_rdy_o <= 1'b0;
         sample_o     <= '0;
      end else begin
         conv_stb_o   <= sample_tick ||
                         (active && !rate_reg[RATE_LOW_POWER] && (state_reg == ST_RUN) &&
                          (timer_reg == (run_period >> 1)));
         sense_on_o   <= active;
         measuring_o  <= measure;
         asleep_o     <= (state_reg == ST_SLEEP) && measure;
         sample_rdy_o <= sample_tick;
         if (sample_tick) begin
            sample_o <= accel_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sample buffer: standby never writes it; a full buffer drops new samples
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         buf_mem[wr_ptr_reg] <= accel_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            level_reg <= level_reg + 1'b1;
         end else if (pop && !push) begin
            level_reg <= level_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [apmc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module apmc_host (
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_n_i,
   apmc_if.host                             link,
   input  wire logic [3:0]                  sw_addr_i,
   input  wire logic [apmc_pkg::DATA_W-1:0] sw_wdata_i,
   input  wire logic                        sw_wr_i,
   input  wire logic                        sw_rd_i,
   output logic [apmc_pkg::DATA_W-1:0]      sw_rdata_o
);
   import apmc_pkg::*;

   typedef enum logic [8:0] {
      H_IDLE = 9'b000000001,
      H_STBY = 9'b000000010,
      H_RATE = 9'b000000100,
      H_THR  = 9'b000001000,
      H_TIME = 9'b000010000,
      H_PWR  = 9'b000100000,
      H_RD   = 9'b001000000,
      H_RDW  = 9'b010000000,
      H_CAP  = 9'b100000000
   } apmc_host_state_t;

   apmc_host_state_t state_reg;
   logic [7:0]       cfg_rate_reg;
   logic [7:0]       cfg_thr_reg;
   logic [7:0]       cfg_time_reg;
   logic [7:0]       cfg_pwr_reg;
   logic [7:0]       raw_addr_reg;
   logic [7:0]       raw_data_reg;
   logic             ctrl_wr;
   logic             rate_lp_ok;
   logic [7:0]       rate_safe;

   assign ctrl_wr    = sw_wr_i && (sw_addr_i == HOFS_CTRL) && (state_reg == H_IDLE);
   assign rate_lp_ok = (cfg_rate_reg[3:0] >= RATE_LP_LO) && (cfg_rate_reg[3:0] <= RATE_LP_HI);
   // low power outside its useful band is stripped
   assign rate_safe  = rate_lp_ok ? cfg_rate_reg
                                  : (cfg_rate_reg & ~(8'h01 << RATE_LOW_POWER));

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_rate_reg <= RST_RATE_CTRL;
         cfg_thr_reg  <= RST_INACT_THRESH;
         cfg_time_reg <= RST_INACT_TIME;
         cfg_pwr_reg  <= RST_POWER_CTRL;
         raw_addr_reg <= '0;
      end else if (sw_wr_i) begin
         unique case (sw_addr_i)
            HOFS_RATE:     cfg_rate_reg <= sw_wdata_i;
            HOFS_THRESH:   cfg_thr_reg  <= sw_wdata_i;
            HOFS_TIME:     cfg_time_reg <= sw_wdata_i;
            HOFS_POWER:    cfg_pwr_reg  <= sw_wdata_i;
            HOFS_RAW_ADDR: raw_addr_reg <= sw_wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_rdata_o <= '0;
      end else if (sw_rd_i) begin
         unique case (sw_addr_i)
            HOFS_RATE:     sw_rdata_o <= cfg_rate_reg;
            HOFS_THRESH:   sw_rdata_o <= cfg_thr_reg;
            HOFS_TIME:     sw_rdata_o <= cfg_time_reg;
            HOFS_POWER:    sw_rdata_o <= cfg_pwr_reg;
            HOFS_STATUS:   sw_rdata_o <= {7'h00, state_reg != H_IDLE};
            HOFS_RAW_ADDR: sw_rdata_o <= raw_addr_reg;
            HOFS_RAW_DATA: sw_rdata_o <= raw_data_reg;
            default:       sw_rdata_o <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // start sequence: standby, rate, threshold, time, then power word
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg    <= H_IDLE;
         link.wr_stb  <= 1'b0;
         link.rd_stb  <= 1'b0;
         link.addr    <= '0;
         link.wdata   <= '0;
         raw_data_reg <= '0;
      end else begin
         link.wr_stb <= 1'b0;
         link.rd_stb <= 1'b0;
         unique case (state_reg)
            H_IDLE: begin
               if (ctrl_wr && sw_wdata_i[CTRL_START]) begin
                  state_reg <= H_STBY;
               end else if (ctrl_wr && sw_wdata_i[CTRL_RAW_RD]) begin
                  state_reg <= H_RD;
               end else if (ctrl_wr && sw_wdata_i[CTRL_RAW_WR]) begin
                  link.wr_stb <= 1'b1;
                  link.addr   <= raw_addr_reg;
                  link.wdata  <= raw_data_reg;
               end
            end
            H_STBY: begin
               link.wr_stb <= 1'b1;
               link.addr   <= ADDR_POWER_CTRL;
               link.wdata  <= 8'h00;
               state_reg   <= H_RATE;
            end
            H_RATE: begin
               link.wr_stb <= 1'b1;
               link.addr   <= ADDR_RATE_CTRL;
               link.wdata  <= rate_safe;
               state_reg   <= H_THR;
            end
            H_THR: begin
               link.wr_stb <= 1'b1;
               link.addr   <= ADDR_INACT_THRESH;
               link.wdata  <= cfg_thr_reg;
               state_reg   <= H_TIME;
            end
            H_TIME: begin
               link.wr_stb <= 1'b1;
               link.addr   <= ADDR_INACT_TIME;
               link.wdata  <= cfg_time_reg;
               state_reg   <= H_PWR;
            end
            H_PWR: begin
               link.wr_stb <= 1'b1;
               link.addr   <= ADDR_POWER_CTRL;
               link.wdata  <= cfg_pwr_reg;
               state_reg   <= H_IDLE;
            end
            H_RD: begin
               link.rd_stb <= 1'b1;
               link.addr   <= raw_addr_reg;
               state_reg   <= H_RDW;
            end
            H_RDW: begin
               state_reg <= H_CAP;
            end
            H_CAP: begin
               raw_data_reg <= link.rdata;
               state_reg    <= H_IDLE;
            end
         endcase
         // software may preload raw data while idle
         if (sw_wr_i && (sw_addr_i == HOFS_RAW_DATA) && (state_reg == H_IDLE)) begin
            raw_data_reg <= sw_wdata_i;
         end
      end
   end
endmodule
`default_nettype wire

// [apmc_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module apmc_properties (
   input wire logic                        sys_clk_i,
   input wire logic                        rst_n_i,
   input wire logic                        wr_stb,
   input wire logic                        rd_stb,
   input wire logic [apmc_pkg::ADDR_W-1:0] addr,
   input wire logic [apmc_pkg::DATA_W-1:0] wdata,
   input wire logic [apmc_pkg::DATA_W-1:0] rdata,
   input wire logic                        measuring_o,
   input wire logic                        asleep_o,
   input wire logic                        sense_on_o,
   input wire logic                        conv_stb_o,
   input wire logic                        sample_rdy_o
);
   import apmc_pkg::*;
   logic [7:0] pwr_shadow_reg;
   logic       pwr_meas;

   ////////////////////////////////////////////////////////////////
   // shadow of power_control, seen from the link side only
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_shadow_reg <= RST_POWER_CTRL;
      end else if (wr_stb && addr == ADDR_POWER_CTRL) begin
         pwr_shadow_reg <= wdata;
      end
   end
   assign pwr_meas = pwr_shadow_reg[PWR_MEASURE];

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_strobes_exclusive: assert property (!(wr_stb && rd_stb))
      else $error("read and write strobes together");
   a_reset_standby: assert property ($rose(rst_n_i) |-> !measuring_o && !sense_on_o)
      else $error("not in standby after reset");
   a_measure_follows: assert property (measuring_o == $past(pwr_meas))
      else $error("measuring does not follow measure bit");
   a_standby_silent: assert property (
      !measuring_o && !sense_on_o |-> !sample_rdy_o && !conv_stb_o)
      else $error("sample or conversion in standby");
   a_first_sample_late: assert property ($rose(sense_on_o) |-> !sample_rdy_o [*8])
      else $error("sample too soon after turn-on");
   a_sample_spacing: assert property (sample_rdy_o |=> !sample_rdy_o [*8])
      else $error("samples closer than shortest period");
   a_rdata_holds: assert property (!$past(rd_stb) |-> $stable(rdata))
      else $error("read data moved without a read");
   a_power_readback: assert property (
      rd_stb && addr == ADDR_POWER_CTRL |=> rdata == $past(pwr_shadow_reg))
      else $error("power control reads back wrong");
   a_sleep_enable: assert property ($rose(asleep_o) |-> pwr_shadow_reg[5:3] == 3'b111)
      else $error("sleep without measure, sleep and pairing bits");

   c_measure: cover property ($rose(measuring_o));
   c_sleep: cover property ($rose(asleep_o));
   c_sample: cover property (sample_rdy_o);
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import apmc_pkg::*;
   localparam int BASE = 16;
   localparam int TON  = 20;
   logic       sys_clk;
   logic       rst_n;
   logic [3:0] sw_addr;
   logic [7:0] sw_wdata;
   logic       sw_wr;
   logic       sw_rd;
   logic [7:0] sw_rdata;
   logic [7:0] accel;
   logic [7:0] sample;
   logic       measuring;
   logic       asleep;
   logic       sense_on;
   logic       conv_stb;
   logic       sample_rdy;
   int         fails;
   int         n_checks;

   apmc_if link_if ();
   // short counts keep the run small
   apmc_device #(.BASE_PERIOD_CYC(32'(BASE)), .TURNON_CYC(32'(TON))) apmc_device_inst (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link_if), .accel_i(accel),
      .measuring_o(measuring), .asleep_o(asleep), .sense_on_o(sense_on),
      .conv_stb_o(conv_stb), .sample_rdy_o(sample_rdy), .sample_o(sample));
   apmc_host apmc_host_inst (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link_if), .sw_addr_i(sw_addr),
      .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata));
   apmc_properties apmc_properties_inst (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .wr_stb(link_if.wr_stb),
      .rd_stb(link_if.rd_stb), .addr(link_if.addr), .wdata(link_if.wdata),
      .rdata(link_if.rdata), .measuring_o(measuring), .asleep_o(asleep),
      .sense_on_o(sense_on), .conv_stb_o(conv_stb), .sample_rdy_o(sample_rdy));

   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge sys_clk);
      sw_wr <= 1'b0;
   endtask

   task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge sys_clk);
      sw_rd <= 1'b0;
      #1;
      d = sw_rdata;
   endtask

   // control writes are dropped while busy, so every order waits here first
   task automatic wait_idle();
      logic [7:0] s;
      int         k;
      k = 0;
      s = 8'h01;
      while (s[0] !== 1'b0 && k < 50) begin
         sw_read(HOFS_STATUS, s);
         k++;
      end
      // a host stuck busy counts as a failure, not a silent pass-through
      chk("host idle", 0, s[0]);
   endtask

   task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
      wait_idle();
      sw_write(HOFS_RAW_ADDR, a);
      sw_write(HOFS_CTRL, 8'h02);
      wait_idle();
      sw_read(HOFS_RAW_DATA, d);
   endtask

   task automatic chk_dev(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      dev_rd(a, d);
      chk("device register", exp, d);
   endtask

   task automatic start(input logic [7:0] r, input logic [7:0] th, input logic [7:0] tm,
                        input logic [7:0] p);
      wait_idle();
      sw_write(HOFS_RATE, r);
      sw_write(HOFS_THRESH, th);
      sw_write(HOFS_TIME, tm);
      sw_write(HOFS_POWER, p);
      sw_write(HOFS_CTRL, 8'h01);
   endtask

   task automatic wait_meas();
      int k;
      k = 0;
      while (measuring !== 1'b0 && k < 20) begin
         @(negedge sys_clk);
         k++;
      end
      while (measuring !== 1'b1 && k < 40) begin
         @(negedge sys_clk);
         k++;
      end
      chk("measuring on", 1, measuring);
   endtask

   task automatic wait_rdy(input int lim, output int n, output int nc);
      n = 0;
      nc = 0;
      do begin
         @(negedge sys_clk);
         n++;
         if (conv_stb === 1'b1) nc++;
      end while (sample_rdy !== 1'b1 && n < lim);
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] d;
      chk("measuring", 0, measuring);
      chk("sensing", 0, sense_on);
      sw_read(HOFS_RATE, d);
      chk("host rate", RST_RATE_CTRL, d);
      chk_dev(ADDR_POWER_CTRL, RST_POWER_CTRL);
      chk_dev(ADDR_RATE_CTRL, RST_RATE_CTRL);
      chk_dev(ADDR_INACT_THRESH, RST_INACT_THRESH);
      chk_dev(ADDR_INACT_TIME, RST_INACT_TIME);
      chk_dev(8'h00, 8'h00);
      wait_idle();
      sw_write(HOFS_RAW_ADDR, ADDR_INACT_TIME);
      sw_write(HOFS_RAW_DATA, 8'h3c);
      sw_write(HOFS_CTRL, 8'h04);
      chk_dev(ADDR_INACT_TIME, 8'h3c);
   endtask

   task automatic t_rates();
      int n;
      int nc;
      int p;
      for (int c = 15; c >= 10; c--) begin
         p = BASE << (15 - c);
         start(8'(c), 8'h00, 8'h00, 8'h08);
         wait_meas();
         wait_rdy(p + TON + 40, n, nc);
         chk("turn-on", 1, n >= p + TON - 2 && n <= p + TON + 4);
         wait_rdy(p + 8, n, nc);
         chk("period", p, n);
         chk("sample", 8'h5a, sample);
         chk("conversions", 2, nc);
      end
      start(8'h1a, 8'h00, 8'h00, 8'h08);
      wait_meas();
      wait_rdy(700, n, nc);
      wait_rdy(600, n, nc);
      chk("low power period", 512, n);
      chk("low power conversions", 1, nc);
      start(8'h1d, 8'h00, 8'h00, 8'h00);
      chk_dev(ADDR_RATE_CTRL, 8'h0d);
   endtask

   task automatic t_standby();
      logic [7:0] lvl;
      logic [7:0] d;
      start(8'h0f, 8'h00, 8'h00, 8'h08);
      repeat (300) @(posedge sys_clk);
      start(8'h0f, 8'h33, 8'h44, 8'h00);
      dev_rd(ADDR_BUF_LEVEL, lvl);
      chk("sensing off", 0, sense_on);
      chk_dev(ADDR_INACT_THRESH, 8'h33);
      chk_dev(ADDR_INACT_TIME, 8'h44);
      dev_rd(ADDR_BUF_LEVEL, d);
      chk("level kept", lvl, d);
      chk("level nonzero", 1, lvl != 8'h00);
      chk_dev(ADDR_SAMPLE_DATA, 8'h5a);
      chk_dev(ADDR_BUF_LEVEL, lvl - 8'h01);
   endtask

   task automatic t_sleep();
      int n;
      int nc;
      int k;
      @(posedge sys_clk);
      accel <= 8'h01;
      start(8'h0f, 8'h10, 8'h02, 8'h18);
      repeat (400) @(posedge sys_clk);
      chk("no pairing no sleep", 0, asleep);
      start(8'h0f, 8'h10, 8'h02, 8'h38);
      k = 0;
      while (asleep !== 1'b1 && k < 400) begin
         @(negedge sys_clk);
         k++;
      end
      chk("asleep", 1, asleep);
      wait_rdy(9000, n, nc);
      wait_rdy(9000, n, nc);
      chk("sleep period", BASE << 9, n);
      @(posedge sys_clk);
      accel <= 8'h7f;
      k = 0;
      while (asleep !== 1'b0 && k < 9000) begin
         @(negedge sys_clk);
         k++;
      end
      chk("awake", 0, asleep);
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      fails = 0;
      n_checks = 0;
      rst_n = 1'b0;
      sw_addr = 4'h0;
      sw_wdata = 8'h00;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      accel = 8'h5a;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_rates();
      t_standby();
      t_sleep();
      stop_test();
   end

   // the whole sequence needs about 29000 cycles
   initial begin
      repeat (60000) @(posedge sys_clk);
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
